// ---- hw/strap_cfg_pkg.sv ----
// constants shared by the reset strap capture block
package strap_cfg_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PLL_W  = 5;
  localparam int unsigned HOLD_W = 2;
  localparam int unsigned CNT_W  = 3;
  localparam int unsigned STRAP_W = 11;
  localparam int unsigned DBG_W  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_PM_CFG2    = 8'h72;
  localparam logic [ADDR_W-1:0] OFF_CLK_CFG    = 8'hE2;
  localparam logic [ADDR_W-1:0] OFF_STRAP_STAT = 8'h74;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned HOLD_LSB    = 4;
  localparam int unsigned CLK_CFG_LSB = 3;
  localparam int unsigned STAT_SERIAL = 0;
  localparam int unsigned STAT_ROM    = 1;
  localparam int unsigned STAT_FLIP   = 2;
  localparam int unsigned STAT_BUS32  = 3;
  localparam int unsigned STAT_DONE   = 4;
  localparam int unsigned STAT_FLOW   = 5;

  // strap vector layout inside the synchroniser
  localparam int unsigned SV_PLL_LSB = 0;
  localparam int unsigned SV_SERIAL  = 5;
  localparam int unsigned SV_ROM     = 6;
  localparam int unsigned SV_MCHK    = 7;
  localparam int unsigned SV_CKE     = 8;
  localparam int unsigned SV_FLIP    = 9;
  localparam int unsigned SV_WIDTH   = 10;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [DATA_W-1:0]  PMCFG_RST     = 8'h00;
  localparam logic [STRAP_W-1:0] STRAP_IDLE    = 11'h7FF;
  localparam logic [PLL_W-1:0]   PLL_RST       = 5'h1F;
  localparam logic [1:0]         HRST_ASSERTED = 2'h0;
  localparam logic [DBG_W-1:0]   DBG_IDLE      = 4'h0;

  // clocks from both hard resets negated to clock-ratio capture
  localparam logic [CNT_W-1:0] CAPTURE_DELAY_CYC = 3'h4;

  typedef enum logic [1:0] {ST_HARD_RESET, ST_PLL_WAIT, ST_RUN} cap_state_t;

endpackage

// ---- hw/sync3.sv ----
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter int unsigned     W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q    <= RST;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= q_d;
    end
  end

endmodule

// ---- hw/reset_strap_config_capture.sv ----
// reset strap capture, pin-function selection and configuration registers
// Functional notes
// (RL1) every strap pin except the five clock-ratio straps is sampled throughout hard reset and its level sets the options.
// (RL2) the five clock-ratio straps are taken a few clocks after both hard resets negate.
// (RL3) strap pull-ups are on only in reset, so an open strap reads one.
// (RL4) pull-ups on bus request and the four test-access inputs are always on.
// (RL5) serial-select one gives legacy PCI clocks, zero gives the dual serial port.
// (RL6) ROM-select one keeps legacy debug and trigger pins, zero gives extended ROM.
// (RL7) the hold-delay field loads the inverted machine-check and clock-enable straps.
// (RL8) with both of those straps high the hold-delay field resets to zero-zero.
// (RL9) in 32-bit mode the unused lanes have receivers off and drive zeros.
// (RL10) data receivers are off whenever no read is in progress.
// (RL11) a low clock-flip strap at reset turns on the clock-flip logic.
// (RL12) no flow-through SDRAM interface is offered.
// (RL13) the captured clock-ratio value reads back in the register at E2 hex.
// (RL14) captured values hold until the next hard reset.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module reset_strap_config_capture
  import strap_cfg_pkg::*;
(
  input  wire logic                             sys_clk,
  input  wire logic                             arst_n,
  input  wire logic                             core_hard_reset_n,
  input  wire logic                             periph_hard_reset_n,
  input  wire logic [strap_cfg_pkg::PLL_W-1:0]  pll_cfg_strap,
  input  wire logic                             serial_select_strap,
  input  wire logic                             rom_select_strap,
  input  wire logic                             machine_check_pin,
  input  wire logic                             cke_strap,
  input  wire logic                             clock_flip_strap,
  input  wire logic                             low_lane_zero_strap,
  input  wire logic                             timebase_enable_pin,
  input  wire logic                             checkstop_input,
  input  wire logic                             soft_reset_input,
  input  wire logic                             trigger_input,
  input  wire logic                             trigger_src,
  input  wire logic                             mem_read_active,
  input  wire logic                             mem_drive_en,
  input  wire logic [31:0]                      high_data_src,
  input  wire logic [31:0]                      low_data_src,
  input  wire logic [7:0]                       parity_src,
  input  wire logic [strap_cfg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [strap_cfg_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [strap_cfg_pkg::DATA_W-1:0] reg_rdata,
  output logic                                  strap_pullup_en,
  output logic      [4:0]                       req_pullup_en,
  output logic      [3:0]                       tap_pullup_en,
  output logic      [4:0]                       pci_clk_out_en,
  output logic                                  serial_port_sel,
  output logic                                  legacy_debug_sel,
  output logic                                  ext_rom_sel,
  output logic                                  timebase_en,
  output logic                                  checkstop_req,
  output logic                                  soft_reset_req,
  output logic                                  trigger_in_evt,
  output logic                                  trigger_output,
  output logic      [strap_cfg_pkg::HOLD_W-1:0] pci_output_hold_delay,
  output logic                                  clock_flip_en,
  output logic                                  bus32_mode,
  output logic                                  high_rcv_en,
  output logic                                  low_rcv_en,
  output logic      [7:0]                       parity_rcv_en,
  output logic      [31:0]                      high_data_lanes,
  output logic      [31:0]                      low_data_lanes,
  output logic      [7:0]                       memory_parity_lanes,
  output logic                                  data_lanes_oe
);

  import strap_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_q;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0]         hrst_s;
  logic [STRAP_W-1:0] strap_s;
  logic [DBG_W-1:0]   dbg_s;
  logic               in_hard_reset;

  sync3 #(.W(2), .RST(HRST_ASSERTED)) u_sync_hrst (
    .clk   (sys_clk),
    .rst_n (rst_q),
    .d     ({core_hard_reset_n, periph_hard_reset_n}),
    .q     (hrst_s)
  );

  sync3 #(.W(STRAP_W), .RST(STRAP_IDLE)) u_sync_strap (
    .clk   (sys_clk),
    .rst_n (rst_q),
    .d     ({low_lane_zero_strap, clock_flip_strap, cke_strap, machine_check_pin,
             rom_select_strap, serial_select_strap, pll_cfg_strap}),
    .q     (strap_s)
  );

  sync3 #(.W(DBG_W), .RST(DBG_IDLE)) u_sync_dbg (
    .clk   (sys_clk),
    .rst_n (rst_q),
    .d     ({trigger_input, soft_reset_input, checkstop_input, timebase_enable_pin}),
    .q     (dbg_s)
  );

  // either hard reset held keeps the whole capture open
  assign in_hard_reset = ~(hrst_s[0] & hrst_s[1]);

  ////////////////////////////////////////////////////////////////////////////
  // capture sequence and configuration registers
  cap_state_t        state_q;
  cap_state_t        state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [PLL_W-1:0]  pll_q;
  logic [PLL_W-1:0]  pll_d;
  logic              serial_q;
  logic              serial_d;
  logic              rom_q;
  logic              rom_d;
  logic              flip_q;
  logic              flip_d;
  logic              width_q;
  logic              width_d;
  logic [DATA_W-1:0] pmcfg_q;
  logic [DATA_W-1:0] pmcfg_d;
  logic [DATA_W-1:0] rdata_d;

  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    pll_d    = pll_q;
    serial_d = serial_q;
    rom_d    = rom_q;
    flip_d   = flip_q;
    width_d  = width_q;
    pmcfg_d  = pmcfg_q;
    if (reg_wr && reg_addr == OFF_PM_CFG2)
    begin
      pmcfg_d = reg_wdata;                                                   // RL7
    end
    unique case (state_q)
      ST_HARD_RESET:
      begin
        // straps follow the pins for as long as reset is held
        serial_d = strap_s[SV_SERIAL];                                       // RL1
        rom_d    = strap_s[SV_ROM];                                          // RL1
        flip_d   = strap_s[SV_FLIP];                                         // RL1
        width_d  = strap_s[SV_WIDTH];                                        // RL1
        // reset load wins over a software write; open straps give 2'b00
        pmcfg_d[HOLD_LSB+1] = ~strap_s[SV_MCHK];                             // RL7 RL8
        pmcfg_d[HOLD_LSB]   = ~strap_s[SV_CKE];                              // RL7 RL8
        cnt_d = '0;
        if (!in_hard_reset)
        begin
          state_d = ST_PLL_WAIT;
        end
      end
      ST_PLL_WAIT:
      begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == CAPTURE_DELAY_CYC - 3'h1)
        begin
          pll_d   = strap_s[SV_PLL_LSB +: PLL_W];                            // RL2
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        // pins are free for their run-time use now; latches stay put
        state_d = ST_RUN;                                                    // RL14
      end
    endcase
    if (in_hard_reset)
    begin
      state_d = ST_HARD_RESET;
    end
  end

  // read answer in the cycle after the strobe only
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFF_PM_CFG2:
        begin
          rdata_d = pmcfg_q;
        end
        OFF_CLK_CFG:
        begin
          rdata_d[CLK_CFG_LSB +: PLL_W] = pll_q;                             // RL13
        end
        OFF_STRAP_STAT:
        begin
          rdata_d[STAT_SERIAL] = serial_q;
          rdata_d[STAT_ROM]    = rom_q;
          rdata_d[STAT_FLIP]   = flip_q;
          rdata_d[STAT_BUS32]  = ~width_q;
          rdata_d[STAT_DONE]   = (state_q == ST_RUN);
          // flow-through mode is not built; its bit always reads zero
          rdata_d[STAT_FLOW]   = 1'b0;                                       // RL12
        end
        default:
        begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state_q   <= ST_HARD_RESET;
      cnt_q     <= '0;
      pll_q     <= PLL_RST;
      serial_q  <= 1'b1;
      rom_q     <= 1'b1;
      flip_q    <= 1'b1;
      width_q   <= 1'b1;
      pmcfg_q   <= PMCFG_RST;
      reg_rdata <= '0;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      pll_q     <= pll_d;
      serial_q  <= serial_d;
      rom_q     <= rom_d;
      flip_q    <= flip_d;
      width_q   <= width_d;
      pmcfg_q   <= pmcfg_d;
      reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin functions steered by the captured straps
  logic        bus32;
  logic [4:0]  clk_en_d;
  logic [3:0]  dbg_d;
  logic        trigger_output_d;
  logic [31:0] low_d;
  logic [7:0]  prty_d;
  logic [7:0]  prty_rcv_d;
  logic        low_rcv_d;
  logic        high_rcv_d;

  assign bus32 = ~width_q;

  always_comb
  begin
    // pci clock four is never shared with the serial port
    clk_en_d   = {1'b1, {4{serial_q}}};                                      // RL5
    dbg_d      = rom_q ? dbg_s : 4'h0;                                       // RL6
    trigger_output_d = rom_q & trigger_src;                                        // RL6
    high_rcv_d = mem_read_active;                                            // RL10
    low_rcv_d  = mem_read_active & ~bus32;                                   // RL9 RL10
    prty_rcv_d = {{4{mem_read_active & ~bus32}}, {4{mem_read_active}}};      // RL9 RL10
    low_d      = bus32 ? 32'h0000_0000 : low_data_src;                       // RL9
    prty_d     = bus32 ? {4'h0, parity_src[3:0]} : parity_src;               // RL9
  end

  always_ff @(posedge sys_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      strap_pullup_en     <= 1'b1;
      pci_clk_out_en      <= 5'h1F;
      serial_port_sel     <= 1'b0;
      legacy_debug_sel    <= 1'b1;
      ext_rom_sel         <= 1'b0;
      timebase_en         <= 1'b0;
      checkstop_req       <= 1'b0;
      soft_reset_req      <= 1'b0;
      trigger_in_evt      <= 1'b0;
      trigger_output      <= 1'b0;
      clock_flip_en       <= 1'b0;
      bus32_mode          <= 1'b0;
      high_rcv_en         <= 1'b0;
      low_rcv_en          <= 1'b0;
      parity_rcv_en       <= 8'h00;
      high_data_lanes     <= 32'h0000_0000;
      low_data_lanes      <= 32'h0000_0000;
      memory_parity_lanes <= 8'h00;
      data_lanes_oe       <= 1'b0;
    end
    else
    begin
      strap_pullup_en     <= in_hard_reset;                                  // RL3
      pci_clk_out_en      <= clk_en_d;                                       // RL5
      serial_port_sel     <= ~serial_q;                                      // RL5
      legacy_debug_sel    <= rom_q;                                          // RL6
      ext_rom_sel         <= ~rom_q;                                         // RL6
      timebase_en         <= dbg_d[0];
      checkstop_req       <= dbg_d[1];
      soft_reset_req      <= dbg_d[2];
      trigger_in_evt      <= dbg_d[3];
      trigger_output      <= trigger_output_d;
      clock_flip_en       <= ~flip_q;                                        // RL11
      bus32_mode          <= bus32;
      high_rcv_en         <= high_rcv_d;
      low_rcv_en          <= low_rcv_d;
      parity_rcv_en       <= prty_rcv_d;
      high_data_lanes     <= high_data_src;
      low_data_lanes      <= low_d;
      memory_parity_lanes <= prty_d;
      data_lanes_oe       <= mem_drive_en;
    end
  end

  // these pull-ups do not depend on reset at all
  assign req_pullup_en = 5'h1F;                                              // RL4
  assign tap_pullup_en = 4'hF;                                               // RL4

  assign pci_output_hold_delay = pmcfg_q[HOLD_LSB +: HOLD_W];                // RL7

endmodule

// ---- sim/strap_board.sv ----
// board strap resistors on the reset configuration pins
`timescale 1ns/1ps
module strap_board #(
  parameter int HOLD_CYC = 12
) (
  input  wire logic        sys_clk,
  input  wire logic        strap_pullup_en,
  input  wire logic [10:0] pull_low,
  output logic      [10:0] strap_pin
);
  int          hold_q = 0;
  logic [10:0] float_q = '1;

  ////////////////////////////////////////////////////////////////////////////
  // open pin keeps the pulled-up level a short while, then floats
  always_ff @(posedge sys_clk)
  begin
    if (strap_pullup_en)
      hold_q <= 0;
    else if (hold_q < HOLD_CYC)
      hold_q <= hold_q + 1;
    if (strap_pullup_en || hold_q < HOLD_CYC)
      float_q <= '1;
    else
      float_q <= ~float_q;
  end

  // a pull-down resistor always wins
  assign strap_pin = ~pull_low & float_q;
endmodule

// ---- sim/reset_strap_config_capture_assertions.sv ----
// concurrent checks on the strap capture block ports
`timescale 1ns/1ps
module strap_cap_checker (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        core_hard_reset_n,
  input wire logic        mem_read_active,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        strap_pullup_en,
  input wire logic [4:0]  req_pullup_en,
  input wire logic [3:0]  tap_pullup_en,
  input wire logic [4:0]  pci_clk_out_en,
  input wire logic        serial_port_sel,
  input wire logic        legacy_debug_sel,
  input wire logic        ext_rom_sel,
  input wire logic        timebase_en,
  input wire logic        trigger_output,
  input wire logic [1:0]  pci_output_hold_delay,
  input wire logic        clock_flip_en,
  input wire logic        bus32_mode,
  input wire logic        high_rcv_en,
  input wire logic        low_rcv_en,
  input wire logic [7:0]  parity_rcv_en,
  input wire logic [31:0] low_data_lanes,
  input wire logic [7:0]  memory_parity_lanes
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_hrst_fall; $fell(core_hard_reset_n); endsequence
  sequence s_pu_on; ##[1:6] strap_pullup_en; endsequence
  sequence s_running; !strap_pullup_en [*3]; endsequence

  property p_pu_reset; s_hrst_fall |-> s_pu_on; endproperty
  a_pu_reset: assert property (p_pu_reset) else $error("strap pull-up late");
  property p_pu_always; req_pullup_en == 5'h1F && tap_pullup_en == 4'hF; endproperty
  a_pu_always: assert property (p_pu_always) else $error("fixed pull-up off");
  property p_serial; pci_clk_out_en == {1'b1, {4{!serial_port_sel}}}; endproperty
  a_serial: assert property (p_serial) else $error("pci clock enables wrong");
  property p_rom; ext_rom_sel != legacy_debug_sel; endproperty
  a_rom: assert property (p_rom) else $error("rom select pair wrong");
  property p_rom_gate;
    ext_rom_sel && $past(ext_rom_sel) |-> !timebase_en && !trigger_output;
  endproperty
  a_rom_gate: assert property (p_rom_gate) else $error("debug pin live in rom mode");
  property p_hold;
    reg_wr && reg_addr == 8'h72 && !strap_pullup_en && core_hard_reset_n
      |=> pci_output_hold_delay == $past(reg_wdata[5:4]);
  endproperty
  a_hold: assert property (p_hold) else $error("hold delay not written");
  property p_bus32;
    bus32_mode && $past(bus32_mode) |-> low_data_lanes == 32'h0 && !low_rcv_en
      && memory_parity_lanes[7:4] == 4'h0 && parity_rcv_en[7:4] == 4'h0;
  endproperty
  a_bus32: assert property (p_bus32) else $error("unused lanes active");
  property p_rcv_off;
    !$past(mem_read_active) |-> !high_rcv_en && parity_rcv_en == 8'h00;
  endproperty
  a_rcv_off: assert property (p_rcv_off) else $error("receiver on without read");
  property p_frozen;
    s_running |-> $stable(serial_port_sel) && $stable(ext_rom_sel)
      && $stable(clock_flip_en) && $stable(bus32_mode);
  endproperty
  a_frozen: assert property (p_frozen) else $error("captured option moved");
endmodule

bind reset_strap_config_capture strap_cap_checker i_chk (
  .sys_clk, .arst_n, .core_hard_reset_n, .mem_read_active, .reg_addr, .reg_wdata,
  .reg_wr, .strap_pullup_en, .req_pullup_en, .tap_pullup_en, .pci_clk_out_en,
  .serial_port_sel, .legacy_debug_sel, .ext_rom_sel, .timebase_en, .trigger_output,
  .pci_output_hold_delay, .clock_flip_en, .bus32_mode, .high_rcv_en, .low_rcv_en,
  .parity_rcv_en, .low_data_lanes, .memory_parity_lanes
);

// ---- sim/test_reset_strap_config_capture.sv ----
// self-checking bench for the reset strap capture block
`timescale 1ns/1ps
module test_reset_strap_config_capture;
  logic        sys_clk, arst_n, core_hard_reset_n, periph_hard_reset_n, reg_wr, reg_rd;
  logic        timebase_enable_pin, checkstop_input, soft_reset_input, trigger_input;
  logic        trigger_src, mem_read_active, mem_drive_en, strap_pullup_en;
  logic        serial_port_sel, legacy_debug_sel, ext_rom_sel, timebase_en, trigger_output;
  logic        clock_flip_en, bus32_mode, high_rcv_en, low_rcv_en;
  logic        checkstop_req, soft_reset_req, trigger_in_evt, data_lanes_oe;
  logic [31:0] high_data_src, low_data_src, high_data_lanes, low_data_lanes;
  logic [7:0]  parity_src, reg_addr, reg_wdata, reg_rdata, parity_rcv_en, memory_parity_lanes;
  logic [10:0] pull_low, strap_pin;
  logic [4:0]  req_pullup_en, pci_clk_out_en;
  logic [3:0]  tap_pullup_en;
  logic [1:0]  pci_output_hold_delay;
  logic [7:0]  d;
  int          fails = 0;
  int          n_compared = 0;

  reset_strap_config_capture i_dut (
    .sys_clk, .arst_n, .core_hard_reset_n, .periph_hard_reset_n,
    .pll_cfg_strap(strap_pin[4:0]), .serial_select_strap(strap_pin[5]),
    .rom_select_strap(strap_pin[6]), .machine_check_pin(strap_pin[7]),
    .cke_strap(strap_pin[8]), .clock_flip_strap(strap_pin[9]),
    .low_lane_zero_strap(strap_pin[10]), .timebase_enable_pin, .checkstop_input,
    .soft_reset_input, .trigger_input, .trigger_src, .mem_read_active, .mem_drive_en,
    .high_data_src, .low_data_src, .parity_src, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .strap_pullup_en, .req_pullup_en, .tap_pullup_en, .pci_clk_out_en,
    .serial_port_sel, .legacy_debug_sel, .ext_rom_sel, .timebase_en, .checkstop_req,
    .soft_reset_req, .trigger_in_evt, .trigger_output, .pci_output_hold_delay,
    .clock_flip_en, .bus32_mode, .high_rcv_en, .low_rcv_en, .parity_rcv_en,
    .high_data_lanes, .low_data_lanes, .memory_parity_lanes, .data_lanes_oe
  );
  strap_board i_board (.sys_clk, .strap_pullup_en, .pull_low, .strap_pin);

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // clock-ratio pulls change after core reset lifts, before the peripheral one
  task automatic hard_reset(input logic [10:0] pl, input logic [4:0] pll_late);
    @(posedge sys_clk);
    core_hard_reset_n <= 1'b0; periph_hard_reset_n <= 1'b0; pull_low <= pl;
    repeat (10) @(posedge sys_clk);
    core_hard_reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pull_low[4:0] <= pll_late;
    repeat (2) @(posedge sys_clk);
    periph_hard_reset_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("compared=%0d failed=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // all straps open: every option takes its pulled-up default
  task automatic s_defaults;
    timebase_enable_pin <= 1'b1; checkstop_input <= 1'b1; soft_reset_input <= 1'b1;
    trigger_input <= 1'b1; trigger_src <= 1'b1;
    hard_reset(11'h000, 5'h00);
    chk(pci_output_hold_delay, 2'h0);
    chk(pci_clk_out_en, 5'h1F);
    chk(legacy_debug_sel, 1'b1);
    chk({timebase_en, checkstop_req, soft_reset_req}, 3'h7);
    chk({trigger_in_evt, trigger_output}, 2'h3);
    chk(clock_flip_en | bus32_mode | strap_pullup_en, 1'b0);
    rd(8'hE2); chk(d, 8'hF8);
    rd(8'h74); chk(d, 8'h17);
    @(posedge sys_clk);
    mem_read_active <= 1'b1; low_data_src <= 32'hA5A5_5A5A;
    repeat (2) @(posedge sys_clk);
    #1 chk(low_data_lanes, 32'hA5A5_5A5A);
    chk(parity_rcv_en, 8'hFF);
    @(posedge sys_clk);
    mem_read_active <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(high_rcv_en | low_rcv_en, 1'b0);
  endtask

  // back-to-back accesses, read-only and unmapped places
  task automatic s_regs;
    wr(8'h72, 8'h30); chk(pci_output_hold_delay, 2'h3);
    rd(8'h72); chk(d, 8'h30);
    wr(8'h72, 8'h1F); rd(8'h72); chk(d, 8'h1F);
    chk(pci_output_hold_delay, 2'h1);
    wr(8'hE2, 8'h00); rd(8'hE2); chk(d, 8'hF8);
    wr(8'h55, 8'hFF); rd(8'h55); chk(d, 8'h00);
  endtask

  // second hard reset with pulled-down straps, then the pins float
  task automatic s_straps;
    hard_reset(11'h6FC, 5'h15);
    chk(pci_output_hold_delay, 2'h2);
    chk(pci_clk_out_en, 5'h10);
    chk(ext_rom_sel & ~timebase_en & ~trigger_output, 1'b1);
    chk({checkstop_req, soft_reset_req, trigger_in_evt}, 3'h0);
    chk(clock_flip_en & bus32_mode, 1'b1);
    rd(8'hE2); chk(d, 8'h50);
    rd(8'h74); chk(d, 8'h18);
    @(posedge sys_clk);
    mem_read_active <= 1'b1; mem_drive_en <= 1'b1; parity_src <= 8'hFF;
    low_data_src <= 32'hFFFF_FFFF; high_data_src <= 32'h1234_5678;
    repeat (2) @(posedge sys_clk);
    #1 chk(low_data_lanes, 32'h0);
    chk(high_data_lanes, 32'h1234_5678);
    chk(data_lanes_oe, 1'b1);
    chk(memory_parity_lanes, 8'h0F);
    chk({high_rcv_en, low_rcv_en, parity_rcv_en}, 10'h20F);
    @(posedge sys_clk);
    pull_low <= 11'h000;
    repeat (40) @(posedge sys_clk);
    rd(8'hE2); chk(d, 8'h50);
    chk({serial_port_sel, ext_rom_sel, clock_flip_en, bus32_mode}, 4'hF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 0; arst_n = 0; core_hard_reset_n = 0; periph_hard_reset_n = 0;
    reg_wr = 0; reg_rd = 0; reg_addr = 8'h00; reg_wdata = 8'h00; pull_low = 11'h000;
    timebase_enable_pin = 0; checkstop_input = 0; soft_reset_input = 0;
    trigger_input = 0; trigger_src = 0; mem_read_active = 0; mem_drive_en = 0;
    high_data_src = 32'h0; low_data_src = 32'h0; parity_src = 8'h00;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    s_defaults;
    s_regs;
    s_straps;
    tally_and_finish;
  end

  // whole run is under two hundred cycles
  initial
  begin
    #200000;
    fails++;
    tally_and_finish;
  end
endmodule
